/* File: verilog/blt_consts.vh */
// Constants for the block-transfer engine control registers
`ifndef BLT_CONSTS_VH
`define BLT_CONSTS_VH

// Register indices as printed; byte address is four times the index
`define BLT_IDX_CTRL        12'h100
`define BLT_IDX_FMT         12'h101
`define BLT_IDX_ROP         12'h102
`define BLT_IDX_OFFSET      12'h10C
`define BLT_IDX_IRQ_STAT    12'h140
`define BLT_IDX_IRQ_MASK    12'h141

// Control/status register fields
`define BLT_CTRL_ACTIVE     7
`define BLT_CTRL_NEMPTY     6
`define BLT_CTRL_HALF       5
`define BLT_CTRL_FULL       4
`define BLT_CTRL_DST_LIN    1
`define BLT_CTRL_SRC_LIN    0

// Format register fields
`define BLT_FMT_BPP16       0

// Raster code register fields
`define BLT_ROP_MSB         3
`define BLT_EXP_MSB         2

// Interrupt status and mask fields
`define BLT_IRQ_DONE        0
`define BLT_IRQ_FULL        1
`define BLT_IRQ_WIDTH       2

// Reset values
`define BLT_CTRL_RST        2'h0
`define BLT_FMT_RST         1'h0
`define BLT_ROP_RST         4'h0
`define BLT_OFFSET_RST      16'h0000
`define BLT_IRQ_RST         2'h0

// Transfer FIFO occupancy thresholds
`define BLT_FIFO_HALF       5'h07
`define BLT_FIFO_FULL       5'h0F

// Address and pixel widths
`define BLT_ADDR_W          21
`define BLT_PIX_W           16

// AHB encodings
`define BLT_HTRANS_NONSEQ   2'h2
`define BLT_HTRANS_SEQ      2'h3
`define BLT_HRESP_OKAY      1'h0

`endif

/* File: verilog/blt_regs.v */
// Control and status registers of the block-transfer engine, AHB-Lite slave
// Functional notes
// - Writing one to the active bit starts the configured operation.
// - Active bit reads one while the engine is busy.
// - Active bit reads zero when idle; write zero while busy is reserved.
// - Not-empty flag reads one when the transfer FIFO holds any word.
// - Full, half and not-empty flags together encode FIFO occupancy ranges.
// - Half-full flag reads one at seven words or more.
// - Full flag reads one when the FIFO is full.
// - The three FIFO flags are read-only; writes leave them alone.
// - Destination layout bit: one linear, zero rectangular.
// - Source layout bit: one linear, zero rectangular.
// - Rectangular lines step by the memory address offset register.
// - Colour format bit selects 8 or 16 bits per pixel.
// - Four-bit raster code is a truth table over source and destination.
// - Low three code bits give the colour expansion start bit.
`include "blt_consts.vh"
`default_nettype none

module blt_regs (
   // Clock and reset
   input  wire                       core_clk,
   input  wire                       rst,
   // AHB-Lite slave
   input  wire                       hsel,
   input  wire [31:0]                haddr,
   input  wire [1:0]                 htrans,
   input  wire                       hwrite,
   input  wire [2:0]                 hsize,
   input  wire [31:0]                hwdata,
   input  wire                       hready,
   output wire                       hreadyout,
   output wire                       hresp,
   output reg  [31:0]                hrdata,
   // Engine sequencing
   output reg                        engStart,
   input  wire                       engDone,
   input  wire [4:0]                 fifoLevel,
   // Line addressing
   input  wire [`BLT_ADDR_W-1:0]     srcStartAddr,
   input  wire [`BLT_ADDR_W-1:0]     dstStartAddr,
   input  wire                       srcLineAdv,
   input  wire                       dstLineAdv,
   output reg  [`BLT_ADDR_W-1:0]     srcLineAddr,
   output reg  [`BLT_ADDR_W-1:0]     dstLineAddr,
   // Pixel format and raster logic
   output reg                        bpp16,
   input  wire [`BLT_PIX_W-1:0]      ropSrc,
   input  wire [`BLT_PIX_W-1:0]      ropDst,
   output reg  [`BLT_PIX_W-1:0]      ropOut,
   output reg  [2:0]                 expStartBit,
   // Interrupt
   output wire                       irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Word index of a byte address
   function [11:0] wordIdx;
      input [31:0] addr;
      begin
         wordIdx = addr[13:2];
      end
   endfunction

   // Truth-table lookup per bit: code bit {s,d} gives the result
   function [`BLT_PIX_W-1:0] ropApply;
      input [3:0]             code;
      input [`BLT_PIX_W-1:0]  s;
      input [`BLT_PIX_W-1:0]  d;
      integer                 i;
      begin
         ropApply = {`BLT_PIX_W{1'b0}};
         for (i = 0; i < `BLT_PIX_W; i = i + 1) begin
            ropApply[i] = code[{s[i], d[i]}];
         end
      end
   endfunction

   // Next line start: linear blocks do not step
   function [`BLT_ADDR_W-1:0] lineStep;
      input                    linear;
      input [`BLT_ADDR_W-1:0]  base;
      input [15:0]             offs;
      begin
         if (linear) begin
            lineStep = base;
         end else begin
            lineStep = base + {{(`BLT_ADDR_W-16){1'b0}}, offs};
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register state

   reg                       busy;
   reg                       dstLinear;
   reg                       srcLinear;
   reg [3:0]                 ropCode;
   reg [15:0]                lineOffset;
   reg [`BLT_IRQ_WIDTH-1:0]  irqStat;
   reg [`BLT_IRQ_WIDTH-1:0]  irqMask;
   reg                       fullSeen;

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite address and data phase

   reg         wrPend;
   reg [11:0]  wrIdx;
   wire        acc;
   wire        rdAcc;

   // Zero wait states; every transfer answers OKAY
   // hsize is not decoded: only whole-word transfers are supported
   assign hreadyout = 1'b1;
   assign hresp     = `BLT_HRESP_OKAY;

   assign acc   = hsel && hready &&
                  (htrans == `BLT_HTRANS_NONSEQ || htrans == `BLT_HTRANS_SEQ);
   assign rdAcc = acc && !hwrite;

   // Write strobe for the data phase that follows an accepted address phase
   always @(posedge core_clk) begin
      if (rst) begin
         wrPend <= 1'b0;
      end else begin
         wrPend <= acc && hwrite;
      end
   end

   // Index held only from an accepted phase, so idle bus traffic cannot move it
   always @(posedge core_clk) begin
      if (rst) begin
         wrIdx <= 12'h000;
      end else if (acc) begin
         wrIdx <= wordIdx(haddr);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register write strobes

   wire wrCtrl   = wrPend && (wrIdx == `BLT_IDX_CTRL);
   wire wrFmt    = wrPend && (wrIdx == `BLT_IDX_FMT);
   wire wrRop    = wrPend && (wrIdx == `BLT_IDX_ROP);
   wire wrOffset = wrPend && (wrIdx == `BLT_IDX_OFFSET);
   wire wrStat   = wrPend && (wrIdx == `BLT_IDX_IRQ_STAT);
   wire wrMask   = wrPend && (wrIdx == `BLT_IDX_IRQ_MASK);

   ////////////////////////////////////////////////////////////////////////////
   // FIFO occupancy flags, decoded from the live level

   // Live decode: a read reports the level seen in its address phase
   wire fifoNotEmpty = (fifoLevel != 5'h00);
   wire fifoHalf     = (fifoLevel >= `BLT_FIFO_HALF);
   wire fifoFull     = (fifoLevel >= `BLT_FIFO_FULL);

   ////////////////////////////////////////////////////////////////////////////
   // Read data, captured in the address phase

   // Taken in the address phase: a read right behind a write to the same
   // register returns the old value, so software leaves one idle cycle
   reg [31:0] next_rdata;

   always @* begin
      next_rdata = 32'h00000000;
      case (wordIdx(haddr))
         `BLT_IDX_CTRL: begin
            next_rdata[`BLT_CTRL_ACTIVE]  = busy;
            next_rdata[`BLT_CTRL_NEMPTY]  = fifoNotEmpty;
            next_rdata[`BLT_CTRL_HALF]    = fifoHalf;
            next_rdata[`BLT_CTRL_FULL]    = fifoFull;
            next_rdata[`BLT_CTRL_DST_LIN] = dstLinear;
            next_rdata[`BLT_CTRL_SRC_LIN] = srcLinear;
         end
         `BLT_IDX_FMT: begin
            next_rdata[`BLT_FMT_BPP16] = bpp16;
         end
         `BLT_IDX_ROP: begin
            next_rdata[3:0] = ropCode;
         end
         `BLT_IDX_OFFSET: begin
            next_rdata[15:0] = lineOffset;
         end
         `BLT_IDX_IRQ_STAT: begin
            next_rdata[`BLT_IRQ_WIDTH-1:0] = irqStat;
         end
         `BLT_IDX_IRQ_MASK: begin
            next_rdata[`BLT_IRQ_WIDTH-1:0] = irqMask;
         end
         default: begin
            next_rdata = 32'h00000000;
         end
      endcase
   end

   // Unmapped reads return zero
   always @(posedge core_clk) begin
      if (rst) begin
         hrdata <= 32'h00000000;
      end else if (rdAcc) begin
         hrdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Active bit: start and busy tracking

   wire startReq = wrCtrl && hwdata[`BLT_CTRL_ACTIVE] && !busy;

   // A one while busy is the running operation itself; a zero is ignored
   always @(posedge core_clk) begin
      if (rst) begin
         busy <= 1'b0;
      end else if (startReq) begin
         busy <= 1'b1;
      end else if (engDone) begin
         busy <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start strobe

   // Registered so the engine sees one clean pulse per accepted start
   always @(posedge core_clk) begin
      if (rst) begin
         engStart <= 1'b0;
      end else begin
         engStart <= startReq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers

   // Layout bits; flag bit positions have no storage, so writes cannot touch them
   always @(posedge core_clk) begin
      if (rst) begin
         {dstLinear, srcLinear} <= `BLT_CTRL_RST;
      end else if (wrCtrl) begin
         dstLinear <= hwdata[`BLT_CTRL_DST_LIN];
         srcLinear <= hwdata[`BLT_CTRL_SRC_LIN];
      end
   end

   // Reserved format bits are dropped; only the pixel size is stored
   always @(posedge core_clk) begin
      if (rst) begin
         bpp16 <= `BLT_FMT_RST;
      end else if (wrFmt) begin
         bpp16 <= hwdata[`BLT_FMT_BPP16];
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         ropCode <= `BLT_ROP_RST;
      end else if (wrRop) begin
         ropCode <= hwdata[`BLT_ROP_MSB:0];
      end
   end

   // Changing the offset mid-operation takes effect on the next line step
   always @(posedge core_clk) begin
      if (rst) begin
         lineOffset <= `BLT_OFFSET_RST;
      end else if (wrOffset) begin
         lineOffset <= hwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt mask

   always @(posedge core_clk) begin
      if (rst) begin
         irqMask <= `BLT_IRQ_RST;
      end else if (wrMask) begin
         irqMask <= hwdata[`BLT_IRQ_WIDTH-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line start addresses

   // A start in the same cycle as a line advance wins: the new operation owns the lines
   always @(posedge core_clk) begin
      if (rst) begin
         srcLineAddr <= {`BLT_ADDR_W{1'b0}};
      end else if (startReq) begin
         srcLineAddr <= srcStartAddr;
      end else if (srcLineAdv) begin
         srcLineAddr <= lineStep(srcLinear, srcLineAddr, lineOffset);
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         dstLineAddr <= {`BLT_ADDR_W{1'b0}};
      end else if (startReq) begin
         dstLineAddr <= dstStartAddr;
      end else if (dstLineAdv) begin
         dstLineAddr <= lineStep(dstLinear, dstLineAddr, lineOffset);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Raster logic and colour expansion start

   // Pattern fill feeds the pattern on the source input
   wire [`BLT_PIX_W-1:0] ropRaw = ropApply(ropCode, ropSrc, ropDst);

   // Upper byte forced low in 8 bpp so stale high bits never reach memory
   always @(posedge core_clk) begin
      if (rst) begin
         ropOut <= {`BLT_PIX_W{1'b0}};
      end else if (bpp16) begin
         ropOut <= ropRaw;
      end else begin
         ropOut <= {8'h00, ropRaw[7:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Colour expansion start

   always @(posedge core_clk) begin
      if (rst) begin
         expStartBit <= 3'h0;
      end else begin
         expStartBit <= ropCode[`BLT_EXP_MSB:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, write one to clear; a new event beats the clear

   wire [`BLT_IRQ_WIDTH-1:0] irqEvt;
   wire [`BLT_IRQ_WIDTH-1:0] irqClr;

   assign irqEvt[`BLT_IRQ_DONE] = busy && engDone && !startReq;
   assign irqEvt[`BLT_IRQ_FULL] = fifoFull && !fullSeen;
   assign irqClr = wrStat ? hwdata[`BLT_IRQ_WIDTH-1:0] : {`BLT_IRQ_WIDTH{1'b0}};

   // Or-ing the event after the clear lets a same-cycle event survive
   always @(posedge core_clk) begin
      if (rst) begin
         irqStat <= `BLT_IRQ_RST;
      end else begin
         irqStat <= (irqStat & ~irqClr) | irqEvt;
      end
   end

   // Starts low, so a FIFO already full out of reset still reports once
   always @(posedge core_clk) begin
      if (rst) begin
         fullSeen <= 1'b0;
      end else begin
         fullSeen <= fifoFull;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt output

   assign irq = |(irqStat & irqMask);

endmodule // blt_regs

`default_nettype wire

/* File: dv/blt_regs_assertions.sv */
// Assertion checker for the block-transfer control registers
`default_nettype none
module blt_regs_checker (
   // Clock and reset
   input wire        core_clk,
   input wire        rst,
   // Register bus
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire [31:0] hrdata,
   // Engine side
   input wire        engStart,
   input wire        engDone,
   input wire [4:0]  fifoLevel,
   input wire        srcLineAdv,
   input wire [20:0] srcLineAddr,
   input wire        bpp16,
   input wire [15:0] ropSrc,
   input wire [15:0] ropDst,
   input wire [15:0] ropOut,
   input wire [2:0]  expStartBit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        wrD, bsy, srcLin;
   logic [11:0] aD;
   logic [3:0]  ropM;
   logic [15:0] offM, ropExp;
   wire take = hsel && hready && htrans[1];
   wire ctlW = wrD && aD == 12'h100;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   // Shadow of what the bus wrote, so outputs can be tied to writes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         {wrD, bsy, srcLin, aD, ropM, offM} <= '0;
      end else begin
         wrD <= take && hwrite;
         if (take) aD <= haddr[13:2];
         if (ctlW && hwdata[7] && !bsy) bsy <= 1'b1;
         else if (engDone) bsy <= 1'b0;
         if (ctlW) srcLin <= hwdata[0];
         if (wrD && aD == 12'h102) ropM <= hwdata[3:0];
         if (wrD && aD == 12'h10C) offM <= hwdata[15:0];
      end
   end
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 16; i++) ropExp[i] <= (i < 8 || bpp16) ? ropM[{ropSrc[i], ropDst[i]}] : 1'b0;
   end
   ////////////////////////////////////////////////////////////
   property p_start; ctlW && hwdata[7] && !bsy |=> engStart; endproperty
   a_start: assert property (p_start)
      else $error("no start pulse after active write");
   property p_pulse; engStart |=> !engStart; endproperty
   a_pulse: assert property (p_pulse)
      else $error("start pulse longer than one cycle");
   property p_ctrl;
      take && !hwrite && haddr[13:2] == 12'h100 |=> hrdata[7:4] ==
         {$past(bsy), $past(fifoLevel) != 0, $past(fifoLevel) > 6, $past(fifoLevel) > 14};
   endproperty
   a_ctrl: assert property (p_ctrl)
      else $error("status read mismatch");
   property p_bpp; wrD && aD == 12'h101 |=> bpp16 == $past(hwdata[0]); endproperty
   a_bpp: assert property (p_bpp)
      else $error("pixel format not taken");
   property p_rop; ropOut == ropExp; endproperty
   a_rop: assert property (p_rop)
      else $error("raster result mismatch");
   property p_exp; expStartBit == $past(ropM[2:0]); endproperty
   a_exp: assert property (p_exp)
      else $error("expansion start bit mismatch");
   property p_rect;
      srcLineAdv && !srcLin && !wrD && !engStart |=> srcLineAddr == $past(srcLineAddr) + $past(offM);
   endproperty
   a_rect: assert property (p_rect)
      else $error("rectangular line step wrong");
   property p_lin; srcLineAdv && srcLin && !wrD && !engStart |=> $stable(srcLineAddr); endproperty
   a_lin: assert property (p_lin)
      else $error("linear source line moved");
endmodule // blt_regs_checker

bind blt_regs blt_regs_checker chk (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hrdata, .engStart, .engDone, .fifoLevel, .srcLineAdv, .srcLineAddr, .bpp16,
   .ropSrc, .ropDst, .ropOut, .expStartBit);
`default_nettype wire

/* File: dv/blt_host.sv */
// Host processor model driving the register bus
`default_nettype none
module blt_host (
   // Clock
   input  wire logic        core_clk,
   // Bus master
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata} = '0;
      hsize = 3'h2;
   end
   // Released lines show the inverse, so a stale value never passes
   task automatic xfer(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge core_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~a;
      hwdata <= d;
      do @(posedge core_clk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~d;
   endtask
endmodule // blt_host
`default_nettype wire

/* File: dv/blit_engine_control_regs_tb.sv */
// Self-checking bench for the block-transfer control registers
`default_nettype none
`include "blt_consts.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module blit_engine_control_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 0, rst = 1, hsel, hwrite, hreadyout, hresp, engStart, engDone, bpp16;
   logic        srcLineAdv, dstLineAdv, irq;
   logic [1:0]  htrans;
   logic [2:0]  hsize, expStartBit;
   logic [4:0]  fifoLevel;
   logic [15:0] ropSrc, ropDst, ropOut;
   logic [20:0] srcStartAddr, dstStartAddr, srcLineAddr, dstLineAddr;
   logic [31:0] haddr, hwdata, hrdata, q;
   int n_mismatch = 0, checked = 0, cyc = 0, starts = 0;
   logic [4:0] lv [7] = '{0, 1, 6, 7, 14, 15, 16};
   localparam logic [31:0] ACTL = {18'h0, `BLT_IDX_CTRL, 2'h0}, AFMT = {18'h0, `BLT_IDX_FMT, 2'h0};
   localparam logic [31:0] AROP = {18'h0, `BLT_IDX_ROP, 2'h0}, AOFF = {18'h0, `BLT_IDX_OFFSET, 2'h0};
   localparam logic [31:0] AIST = {18'h0, `BLT_IDX_IRQ_STAT, 2'h0};
   localparam logic [31:0] AIMK = {18'h0, `BLT_IDX_IRQ_MASK, 2'h0};
   always #12.5 core_clk = ~core_clk;
   blt_host host (.core_clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata);
   blt_regs dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .engStart, .engDone, .fifoLevel,
      .srcStartAddr, .dstStartAddr, .srcLineAdv, .dstLineAdv, .srcLineAddr, .dstLineAddr,
      .bpp16, .ropSrc, .ropDst, .ropOut, .expStartBit, .irq);
   ////////////////////////////////////////////////////////////
   task wr(input logic [31:0] a, d);
      host.xfer(1'b1, a, d, q);
   endtask
   task rd(input string n, input logic [31:0] a, e);
      host.xfer(1'b0, a, 32'h0, q);
      `CHK(n, e, q)
      `CHK("hresp", `BLT_HRESP_OKAY, hresp)
   endtask
   task pulse(input logic [2:0] m);
      @(posedge core_clk) {engDone, srcLineAdv, dstLineAdv} <= m;
      @(posedge core_clk) {engDone, srcLineAdv, dstLineAdv} <= 3'h0;
      @(negedge core_clk);
   endtask
   task end_of_test;
      $display("%0d compared, %0d mismatched", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Hang guard; the whole sequence needs well under a thousand cycles
   always @(posedge core_clk) begin
      cyc++;
      if (engStart === 1'b1) starts++;
      if (cyc == 3000) begin
         n_mismatch++;
         end_of_test;
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      {engDone, srcLineAdv, dstLineAdv, fifoLevel} = '0;
      {srcStartAddr, dstStartAddr, ropSrc, ropDst} = {21'h01000, 21'h02000, 16'hCCCC, 16'hAAAA};
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      rd("ctrl", ACTL, 32'h0);
      rd("fmt", AFMT, 32'h0);
      rd("rop", AROP, 32'h0);
      rd("offset", AOFF, 32'h0);
      rd("irqMask", AIMK, 32'h0);
      $display("test reset done");
      foreach (lv[i]) begin
         @(posedge core_clk) fifoLevel <= lv[i];
         rd("flags", ACTL, {25'h0, lv[i] > 0, lv[i] > 6, lv[i] > 14, 4'h0});
      end
      @(posedge core_clk) fifoLevel <= 5'h00;
      wr(ACTL, 32'h70);
      rd("flags", ACTL, 32'h0);
      rd("irqStat", AIST, 32'h2);
      wr(AIST, 32'h3);
      rd("irqStat", AIST, 32'h0);
      wr(32'h600, 32'hFFFFFFFF);
      rd("unmapped", 32'h600, 32'h0);
      $display("test flags done");
      wr(AOFF, 32'h100);
      wr(ACTL, 32'h80);
      pulse(3'h0);
      `CHK("srcLine", 21'h01000, srcLineAddr)
      pulse(3'h3);
      `CHK("srcLine", 21'h01100, srcLineAddr)
      `CHK("dstLine", 21'h02100, dstLineAddr)
      rd("ctrl", ACTL, 32'h80);
      wr(ACTL, 32'h00);
      wr(ACTL, 32'h80);
      rd("ctrl", ACTL, 32'h80);
      pulse(3'h4);
      rd("ctrl", ACTL, 32'h0);
      `CHK("starts", 1, starts)
      rd("irqStat", AIST, 32'h1);
      `CHK("irq", 1'b0, irq)
      wr(AIMK, 32'h3);
      pulse(3'h0);
      `CHK("irq", 1'b1, irq)
      wr(AIST, 32'h1);
      pulse(3'h0);
      `CHK("irq", 1'b0, irq)
      wr(ACTL, 32'h83);
      pulse(3'h0);
      pulse(3'h3);
      `CHK("srcLine", 21'h01000, srcLineAddr)
      `CHK("dstLine", 21'h02000, dstLineAddr)
      pulse(3'h4);
      $display("test start done");
      wr(AFMT, 32'h1);
      @(negedge core_clk);
      `CHK("bpp16", 1'b1, bpp16)
      for (int c = 0; c < 16; c++) begin
         wr(AROP, c);
         pulse(3'h0);
         `CHK("ropOut", {4{c[3:0]}}, ropOut)
         `CHK("expStart", c[2:0], expStartBit)
         rd("rop", AROP, c);
      end
      wr(AFMT, 32'h0);
      wr(AROP, 32'h6);
      pulse(3'h0);
      `CHK("ropOut", 16'h0066, ropOut)
      rd("fmt", AFMT, 32'h0);
      $display("test raster done");
      end_of_test;
   end
endmodule // blit_engine_control_regs_tb
`default_nettype wire
